// ==== rtc_host_model.sv ====
// rtc_host_model: AXI4-Lite master standing in for the host controller.
// assumes one caller at a time; the bench calls wr and rd by hierarchy.
`timescale 1ns/1ns
module rtc_host_model (
    input  wire logic        clk_i,
    output logic [5:0]       awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [5:0]       araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    // every access ends within a few cycles, far inside one second
    task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw_go, w_go, aw_done, w_done;
        aw_done = 1'h0;
        w_done  = 1'h0;
        @(posedge clk_i);
        awaddr_o  <= a;
        wdata_o   <= {24'h000000, d};
        wstrb_o   <= 4'hF;
        {awvalid_o, wvalid_o, bready_o} <= 3'h7;
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            aw_go = awvalid_o && awready_i;
            w_go  = wvalid_o && wready_i;
            // released payload is scrambled so nothing relies on stale values
            if (aw_go) begin
                awvalid_o <= 1'h0;
                awaddr_o  <= ~a;
                aw_done = 1'h1;
            end
            if (w_go) begin
                wvalid_o <= 1'h0;
                wdata_o  <= ~wdata_o;
                w_done = 1'h1;
            end
        end
        do @(posedge clk_i); while (bvalid_i !== 1'h1);
        r = bresp_i;
        bready_o <= 1'h0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        logic go;
        go = 1'h0;
        @(posedge clk_i);
        araddr_o <= a;
        {arvalid_o, rready_o} <= 2'h3;
        while (!go) begin
            @(posedge clk_i);
            go = arready_i;
        end
        arvalid_o <= 1'h0;
        araddr_o  <= ~a;
        do @(posedge clk_i); while (rvalid_i !== 1'h1);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'h0;
    endtask : rd
endmodule : rtc_host_model

// ==== rtc_pkg.sv ====
// rtc_pkg: register indices, field positions, reset values and bus codes of
// the time and calendar counter block.
// assumes a 32-bit AXI4-Lite register bus; byte address is four times an index.
package rtc_pkg;
    localparam int          ADDR_W        = 6;
    localparam int          IDX_LSB       = 2;
    // register indices (word slots)
    localparam logic [3:0]  IDX_CTRL      = 4'h0;
    localparam logic [3:0]  IDX_SECONDS   = 4'h3;
    localparam logic [3:0]  IDX_MINUTES   = 4'h4;
    localparam logic [3:0]  IDX_HOURS     = 4'h5;
    localparam logic [3:0]  IDX_DAY       = 4'h6;
    localparam logic [3:0]  IDX_WEEKDAY   = 4'h7;
    localparam logic [3:0]  IDX_MONTH     = 4'h8;
    localparam logic [3:0]  IDX_YEAR      = 4'h9;
    // field positions
    localparam int          OS_BIT        = 7;
    localparam int          MERIDIEM_BIT  = 5;
    localparam int          CTRL_FMT_BIT  = 0;
    localparam int          CTRL_HOLD_BIT = 1;
    localparam int          CTRL_RUN_BIT  = 2;
    // reset values
    localparam logic [6:0]  SEC_RST       = 7'h00;
    localparam logic [6:0]  MIN_RST       = 7'h00;
    localparam logic [5:0]  HOUR_RST      = 6'h00;
    localparam logic [5:0]  DAY_RST       = 6'h01;
    localparam logic [2:0]  WDAY_RST      = 3'h0;
    localparam logic [4:0]  MON_RST       = 5'h01;
    localparam logic [7:0]  YEAR_RST      = 8'h00;
    // counter limits in BCD
    localparam logic [6:0]  SEC_LAST      = 7'h59;
    localparam logic [6:0]  MIN_LAST      = 7'h59;
    localparam logic [5:0]  HOUR24_LAST   = 6'h23;
    localparam logic [4:0]  HOUR12_TOP    = 5'h12;
    localparam logic [4:0]  HOUR12_ELEVEN = 5'h11;
    localparam logic [4:0]  HOUR12_FIRST  = 5'h01;
    localparam logic [2:0]  WDAY_LAST     = 3'h6;
    localparam logic [4:0]  MON_FEB       = 5'h02;
    localparam logic [4:0]  MON_DEC       = 5'h12;
    // bus response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : rtc_pkg

// ==== rtc_time_calendar.sv ====
// rtc_time_calendar: BCD time and calendar counters with oscillator-stop flag,
// AXI4-Lite register slave and access freeze with one held-back tick.
// assumes tick_1hz_i and osc_running_i come from the oscillator domain.
//
// Functional notes
// - bit 7 of seconds flags oscillator stop; 1 means time untrustworthy.
// - flag sets whenever oscillator stops, stays until host write clears it.
// - clearing the flag is ignored while the oscillator is not running.
// - flag forced to 1 at reset; oscillator counts stopped until stable.
// - seconds BCD: tens 0-5 in bits 6-4, units 0-9 in bits 3-0.
// - minutes BCD: tens 0-5 in bits 6-4, units bits 3-0, top unused.
// - 12-hour: bit 5 meridiem, bit 4 tens, bits 3-0 units.
// - 24-hour: bits 5-4 tens 0-2, bits 3-0 units, bits 7-6 unused.
// - a control bit selects 12-hour or 24-hour hours encoding.
// - day BCD: tens 0-3 in bits 5-4, units bits 3-0.
// - February has day 29 when year value divisible by 4, 00 included.
// - weekday is 3 bits, values 0 to 6, meaning reassignable.
// - month BCD: tens bit 4, units bits 3-0, January 01 to December 12.
// - year BCD: tens bits 7-4, units bits 3-0.
// - time chain advances on a 1 Hz tick from the oscillator.
// - counters frozen while a host access is in progress.
// - one tick arriving while frozen is held and applied on release.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module rtc_time_calendar (
    input  wire logic                      clk_i,
    input  wire logic                      srst_i,
    input  wire logic                      tick_1hz_i,
    input  wire logic                      osc_running_i,
    input  wire logic [rtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [rtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    typedef struct packed {
        logic       tick_s1;
        logic       tick_s2;
        logic       tick_s3;
        logic       osc_s1;
        logic       osc_s2;
        logic       os_flag;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [5:0] day;
        logic [2:0] wday;
        logic [4:0] mon;
        logic [7:0] year;
        logic       fmt_12h;
        logic       hold;
        logic       pend;
        logic       aw_got;
        logic [3:0] aw_idx;
        logic       w_got;
        logic [7:0] w_byte;
        logic       w_lane0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } rtc_state_t;

    rtc_state_t st_q;
    rtc_state_t st_d;

    logic       tick_edge;
    logic       freeze;
    logic       apply;
    logic       do_write;
    logic       leap;
    logic       hour_last;
    logic       c_min;
    logic       c_hour;
    logic       c_day;
    logic       c_mon;
    logic       c_year;
    logic [5:0] dim;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
    endfunction : bcd_inc

    function automatic logic [7:0] read_reg(input logic [3:0] idx, input rtc_state_t s);
        case (idx)
            rtc_pkg::IDX_CTRL:    read_reg = {5'h00, s.osc_s2, s.hold, s.fmt_12h};
            rtc_pkg::IDX_SECONDS: read_reg = {s.os_flag, s.sec};
            rtc_pkg::IDX_MINUTES: read_reg = {1'b0, s.min};
            rtc_pkg::IDX_HOURS:   read_reg = {2'b00, s.hour};
            rtc_pkg::IDX_DAY:     read_reg = {2'b00, s.day};
            rtc_pkg::IDX_WEEKDAY: read_reg = {5'h00, s.wday};
            rtc_pkg::IDX_MONTH:   read_reg = {3'h0, s.mon};
            rtc_pkg::IDX_YEAR:    read_reg = s.year;
            default:              read_reg = 8'h00;
        endcase
    endfunction : read_reg

    function automatic logic mapped(input logic [3:0] idx);
        mapped = (idx == rtc_pkg::IDX_CTRL) ||
                 ((idx >= rtc_pkg::IDX_SECONDS) && (idx <= rtc_pkg::IDX_YEAR));
    endfunction : mapped

    // ready terms are combinational; a pending response blocks new requests on its own channel (bvalid writes, rvalid reads)
    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rresp   = st_q.rresp;
    assign s_axi_rdata   = {24'h000000, st_q.rdata};

    assign do_write  = st_q.aw_got && st_q.w_got;
    assign tick_edge = st_q.tick_s2 && !st_q.tick_s3;
    // any bus activity or the software hold bit blocks counting
    assign freeze    = st_q.hold || s_axi_awvalid || s_axi_wvalid || s_axi_arvalid ||
                       st_q.aw_got || st_q.w_got || st_q.bvalid || st_q.rvalid;
    assign apply     = (tick_edge || st_q.pend) && !freeze;

    // year divisible by 4 in BCD: even tens with 0/4/8, odd tens with 2/6
    assign leap = st_q.year[4] ? ((st_q.year[3:0] == 4'h2) || (st_q.year[3:0] == 4'h6))
                               : ((st_q.year[3:0] == 4'h0) || (st_q.year[3:0] == 4'h4) ||
                                  (st_q.year[3:0] == 4'h8));

    always_comb begin
        case (st_q.mon)
            rtc_pkg::MON_FEB:           dim = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: dim = 6'h30;
            default:                    dim = 6'h31;
        endcase
    end

    assign hour_last = st_q.fmt_12h ? (st_q.hour[4:0] == rtc_pkg::HOUR12_ELEVEN &&
                                       st_q.hour[rtc_pkg::MERIDIEM_BIT])
                                    : (st_q.hour == rtc_pkg::HOUR24_LAST);
    assign c_min  = apply && (st_q.sec == rtc_pkg::SEC_LAST);
    assign c_hour = c_min && (st_q.min == rtc_pkg::MIN_LAST);
    assign c_day  = c_hour && hour_last;
    assign c_mon  = c_day && (st_q.day == dim);
    assign c_year = c_mon && (st_q.mon == rtc_pkg::MON_DEC);

    always_comb begin
        st_d = st_q;
        // two-flop synchronisers; stage three only serves the edge detector
        st_d.tick_s1 = tick_1hz_i;
        st_d.tick_s2 = st_q.tick_s1;
        st_d.tick_s3 = st_q.tick_s2;
        st_d.osc_s1  = osc_running_i;
        st_d.osc_s2  = st_q.osc_s1;

        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_got = 1'b1;
            st_d.aw_idx = s_axi_awaddr[rtc_pkg::ADDR_W-1:rtc_pkg::IDX_LSB];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_got   = 1'b1;
            st_d.w_byte  = s_axi_wdata[7:0];
            st_d.w_lane0 = s_axi_wstrb[0];
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (do_write) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = mapped(st_q.aw_idx) ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
            if (st_q.w_lane0) begin
                case (st_q.aw_idx)
                    rtc_pkg::IDX_CTRL: begin
                        st_d.fmt_12h = st_q.w_byte[rtc_pkg::CTRL_FMT_BIT];
                        st_d.hold    = st_q.w_byte[rtc_pkg::CTRL_HOLD_BIT];
                    end
                    rtc_pkg::IDX_SECONDS: begin
                        st_d.os_flag = st_q.w_byte[rtc_pkg::OS_BIT];
                        st_d.sec     = st_q.w_byte[6:0];
                    end
                    rtc_pkg::IDX_MINUTES: st_d.min  = st_q.w_byte[6:0];
                    rtc_pkg::IDX_HOURS:   st_d.hour = st_q.w_byte[5:0];
                    rtc_pkg::IDX_DAY:     st_d.day  = st_q.w_byte[5:0];
                    rtc_pkg::IDX_WEEKDAY: st_d.wday = st_q.w_byte[2:0];
                    rtc_pkg::IDX_MONTH:   st_d.mon  = st_q.w_byte[4:0];
                    rtc_pkg::IDX_YEAR:    st_d.year = st_q.w_byte;
                    default: begin
                    end
                endcase
            end
        end

        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = read_reg(s_axi_araddr[rtc_pkg::ADDR_W-1:rtc_pkg::IDX_LSB], st_q);
            st_d.rresp  = mapped(s_axi_araddr[rtc_pkg::ADDR_W-1:rtc_pkg::IDX_LSB]) ?
                          rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
        end

        // a tick during a freeze is held; at release with a fresh tick the
        // held one is applied now and the fresh one stays held
        if (freeze) begin
            st_d.pend = st_q.pend || tick_edge;
        end else begin
            st_d.pend = st_q.pend && tick_edge;
        end

        if (apply) begin
            st_d.sec = (st_q.sec == rtc_pkg::SEC_LAST) ? 7'h00 : 7'(bcd_inc({1'b0, st_q.sec}));
        end
        if (c_min) begin
            st_d.min = (st_q.min == rtc_pkg::MIN_LAST) ? 7'h00 : 7'(bcd_inc({1'b0, st_q.min}));
        end
        if (c_hour) begin
            if (st_q.fmt_12h) begin
                if (st_q.hour[4:0] == rtc_pkg::HOUR12_TOP) begin
                    st_d.hour[4:0] = rtc_pkg::HOUR12_FIRST;
                end else if (st_q.hour[4:0] == rtc_pkg::HOUR12_ELEVEN) begin
                    st_d.hour[4:0] = rtc_pkg::HOUR12_TOP;
                    st_d.hour[rtc_pkg::MERIDIEM_BIT] = !st_q.hour[rtc_pkg::MERIDIEM_BIT];
                end else begin
                    st_d.hour[4:0] = 5'(bcd_inc({3'h0, st_q.hour[4:0]}));
                end
            end else begin
                st_d.hour = hour_last ? 6'h00 : 6'(bcd_inc({2'b00, st_q.hour}));
            end
        end
        if (c_day) begin
            st_d.day  = (st_q.day == dim) ? 6'h01 : 6'(bcd_inc({2'b00, st_q.day}));
            st_d.wday = (st_q.wday == rtc_pkg::WDAY_LAST) ? 3'h0 : 3'(st_q.wday + 3'h1);
        end
        if (c_mon) begin
            st_d.mon = c_year ? 5'h01 : 5'(bcd_inc({3'h0, st_q.mon}));
        end
        if (c_year) begin
            st_d.year = (st_q.year == 8'h99) ? 8'h00 : bcd_inc(st_q.year);
        end

        // stop detection beats a host clear in the same cycle
        if (!st_q.osc_s2) begin
            st_d.os_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q         <= '0;
            st_q.os_flag <= 1'b1;
            st_q.sec     <= rtc_pkg::SEC_RST;
            st_q.min     <= rtc_pkg::MIN_RST;
            st_q.hour    <= rtc_pkg::HOUR_RST;
            st_q.day     <= rtc_pkg::DAY_RST;
            st_q.wday    <= rtc_pkg::WDAY_RST;
            st_q.mon     <= rtc_pkg::MON_RST;
            st_q.year    <= rtc_pkg::YEAR_RST;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_tick_frozen;
        tick_edge && freeze;
    endsequence
    sequence s_release_held;
        st_q.pend && !freeze;
    endsequence
    sequence s_feb28_leap_end;
        c_day && (st_q.mon == rtc_pkg::MON_FEB) && (st_q.day == 6'h28) && leap;
    endsequence
    sequence s_sec_write_stopped;
        do_write && st_q.w_lane0 && (st_q.aw_idx == rtc_pkg::IDX_SECONDS) && !st_q.osc_s2;
    endsequence
    sequence s_sec_write_running;
        do_write && st_q.w_lane0 && (st_q.aw_idx == rtc_pkg::IDX_SECONDS) && st_q.osc_s2;
    endsequence

    // integrity flag

    AST_OS_STOP_SETS: assert property (
        !st_q.osc_s2 |=> st_q.os_flag)
        else $error("osc flag not set while oscillator stopped");
    AST_OS_KEPT: assert property (
        st_q.os_flag && !do_write |=> st_q.os_flag)
        else $error("osc flag dropped without a host write");
    AST_OS_AFTER_RESET: assert property (
        $fell(srst_i) |-> st_q.os_flag)
        else $error("osc flag not set after reset");
    AST_OS_CLEAR_BLOCKED: assert property (
        s_sec_write_stopped |=> st_q.os_flag)
        else $error("osc flag cleared while oscillator stopped");
    AST_OS_LOADED: assert property (
        s_sec_write_running |=> st_q.os_flag == $past(st_q.w_byte[rtc_pkg::OS_BIT]))
        else $error("osc flag does not follow written bit");

    // freeze and held tick

    AST_TICK_HELD: assert property (
        s_tick_frozen |=> st_q.pend)
        else $error("tick during freeze was lost");
    AST_HELD_APPLIED: assert property (
        s_release_held |-> apply ##1 (!st_q.pend || $past(tick_edge)))
        else $error("held tick not applied at release");
    AST_PEND_CLEARS: assert property (
        st_q.pend && !freeze && !tick_edge |=> !st_q.pend)
        else $error("held tick applied but still pending");
    AST_FROZEN_STABLE: assert property (
        freeze && !do_write |=> $stable(st_q.sec) && $stable(st_q.min) && $stable(st_q.year))
        else $error("counters moved during host access");

    // seconds, minutes and hours

    AST_SEC_STEP: assert property (
        apply && st_q.sec[3:0] < 4'h9 |=> st_q.sec == $past(st_q.sec) + 7'h01)
        else $error("seconds not stepped on tick");
    AST_SEC_WRAP: assert property (
        apply && st_q.sec == rtc_pkg::SEC_LAST |=> st_q.sec == 7'h00)
        else $error("seconds did not wrap to 00");
    AST_MIN_STEP: assert property (
        c_min && st_q.min[3:0] < 4'h9 |=> st_q.min == $past(st_q.min) + 7'h01)
        else $error("minutes not stepped on seconds carry");
    AST_HOUR24_WRAP: assert property (
        c_hour && !st_q.fmt_12h && st_q.hour == rtc_pkg::HOUR24_LAST |=>
        st_q.hour == 6'h00 && st_q.day != $past(st_q.day))
        else $error("24-hour wrap or day carry wrong");
    AST_HOUR12_NOON: assert property (
        c_hour && st_q.fmt_12h && st_q.hour == 6'h11 |=> st_q.hour == 6'h32)
        else $error("11 AM did not become 12 PM");
    AST_HOUR12_ONE: assert property (
        c_hour && st_q.fmt_12h && st_q.hour[4:0] == rtc_pkg::HOUR12_TOP |=>
        st_q.hour[4:0] == rtc_pkg::HOUR12_FIRST && $stable(st_q.hour[rtc_pkg::MERIDIEM_BIT]))
        else $error("12 did not step to 1 in the same half day");
    AST_HOUR12_MIDNIGHT: assert property (
        c_hour && st_q.fmt_12h && hour_last |=> st_q.hour == 6'h12 && st_q.day != $past(st_q.day))
        else $error("11 PM did not become 12 AM with day carry");

    // calendar

    AST_LEAP_DAY: assert property (
        s_feb28_leap_end |=> st_q.day == 6'h29 && st_q.mon == rtc_pkg::MON_FEB)
        else $error("leap February lacks day 29");
    AST_FEB_PLAIN: assert property (
        c_day && st_q.mon == rtc_pkg::MON_FEB && st_q.day == 6'h28 && !leap |=>
        st_q.day == 6'h01 && st_q.mon == 5'h03)
        else $error("common February did not end on day 28");
    AST_DAY_WRAP: assert property (
        c_day && st_q.day == dim |=> st_q.day == 6'h01)
        else $error("day did not wrap to 01 after month end");
    AST_WDAY_WRAP: assert property (
        c_day && st_q.wday == rtc_pkg::WDAY_LAST |=> st_q.wday == 3'h0)
        else $error("weekday did not wrap to 0");
    AST_MON_STEP: assert property (
        c_mon && !c_year |=> st_q.mon != $past(st_q.mon) && st_q.day == 6'h01)
        else $error("month not stepped at month end");
    AST_DEC_WRAP: assert property (
        c_year |=> st_q.mon == 5'h01 && st_q.day == 6'h01)
        else $error("December did not roll to January 1");
    AST_YEAR_WRAP: assert property (
        c_year && st_q.year == 8'h99 |=> st_q.year == 8'h00)
        else $error("year 99 did not wrap to 00");
endmodule : rtc_time_calendar

// ==== testbench.sv ====
// testbench: drives the counter block through the host model plus the tick and
// oscillator inputs; assumes the tick input is a slow level sampled by the block.
`timescale 1ns/1ns
module testbench;
    logic        clk_i = 1'h0, srst_i = 1'h1, tick = 1'h0, osc = 1'h0;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          fail_count = 0, n_checks = 0;
    always #20 clk_i = ~clk_i;
    rtc_time_calendar rtc_time_calendar_inst (.clk_i(clk_i), .srst_i(srst_i),
        .tick_1hz_i(tick), .osc_running_i(osc), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    rtc_host_model rtc_host_model_inst (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
        .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
        .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_chk(input logic [3:0] i, input logic [7:0] d,
                          input logic [1:0] er = rtc_pkg::RESP_OKAY);
        logic [1:0] r;
        rtc_host_model_inst.wr({i, 2'h0}, d, r);
        chk({32'h0, r}, {32'h0, er});
    endtask : wr_chk
    task automatic rd_chk(input logic [3:0] i, input logic [7:0] e,
                          input logic [1:0] er = rtc_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        rtc_host_model_inst.rd({i, 2'h0}, d, r);
        chk({r, d}, {er, 24'h0, e});
    endtask : rd_chk
    task automatic pulse;
        @(posedge clk_i) tick <= 1'h1;
        repeat (6) @(posedge clk_i);
        tick <= 1'h0;
        repeat (6) @(posedge clk_i);
    endtask : pulse
    function automatic logic [7:0] inc_bcd(input logic [7:0] v);
        if (v == 8'h59) return 8'h00;
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction : inc_bcd
    function automatic logic leap(input logic [7:0] y);
        return ((y[7:4] * 10 + y[3:0]) % 4) == 0;
    endfunction : leap
    // all seven fields loaded under hold, so no tick lands between them
    task automatic corner(input logic fmt, input logic [55:0] s, input logic [55:0] e);
        wr_chk(4'h0, {6'h00, 1'h1, fmt});
        for (int i = 0; i < 7; i++) wr_chk(4'(3 + i), s[55 - 8 * i -: 8]);
        wr_chk(4'h0, {7'h00, fmt});
        pulse();
        for (int i = 0; i < 7; i++) rd_chk(4'(3 + i), e[55 - 8 * i -: 8]);
    endtask : corner
    initial begin
        repeat (30000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    initial begin
        logic [7:0] y, s;
        void'($urandom(32'h9BA71DB0));
        repeat (4) @(posedge clk_i);
        srst_i <= 1'h0;
        rd_chk(4'h3, 8'h80);
        rd_chk(4'h6, 8'h01);
        rd_chk(4'h8, 8'h01);
        wr_chk(4'h3, 8'h00);
        rd_chk(4'h3, 8'h80);
        osc <= 1'h1;
        repeat (4) @(posedge clk_i);
        rd_chk(4'h0, 8'h04);
        wr_chk(4'h3, 8'h00);
        rd_chk(4'h3, 8'h00);
        osc <= 1'h0;
        repeat (4) @(posedge clk_i);
        osc <= 1'h1;
        repeat (4) @(posedge clk_i);
        rd_chk(4'h3, 8'h80);
        wr_chk(4'h3, 8'h00);
        wr_chk(4'hA, 8'h55, rtc_pkg::RESP_SLVERR);
        rd_chk(4'hA, 8'h00, rtc_pkg::RESP_SLVERR);
        for (int k = 0; k < 6; k++) begin
            s = {1'h0, 3'($urandom_range(5)), 4'($urandom_range(9))};
            wr_chk(4'h3, s);
            pulse();
            rd_chk(4'h3, inc_bcd(s));
        end
        corner(1'h0, 56'h59_59_23_31_06_12_99, 56'h00_00_00_01_00_01_00);
        corner(1'h0, 56'h59_59_23_31_06_12_99, 56'h00_00_00_01_00_01_00);
        corner(1'h0, 56'h59_59_23_30_03_04_21, 56'h00_00_00_01_04_05_21);
        corner(1'h0, 56'h59_59_23_29_05_02_00, 56'h00_00_00_01_06_03_00);
        for (int k = 0; k < 4; k++) begin
            y = {4'($urandom_range(9)), 4'($urandom_range(9))};
            corner(1'h0, {40'h59_59_23_28_01, 8'h02, y}, {24'h00_00_00, leap(y) ? 8'h29 : 8'h01,
                   8'h02, leap(y) ? 8'h02 : 8'h03, y});
        end
        corner(1'h1, 56'h59_59_31_15_02_07_10, 56'h00_00_12_16_03_07_10);
        corner(1'h1, 56'h59_59_11_15_02_07_10, 56'h00_00_32_15_02_07_10);
        corner(1'h1, 56'h59_59_32_15_02_07_10, 56'h00_00_21_15_02_07_10);
        wr_chk(4'h0, 8'h02);
        wr_chk(4'h3, 8'h10);
        pulse();
        pulse();
        rd_chk(4'h3, 8'h10);
        wr_chk(4'h0, 8'h00);
        repeat (4) @(posedge clk_i);
        rd_chk(4'h3, 8'h11);
        close_out();
    end
endmodule : testbench
